// ---- hw/gpio_pkg.sv ----
package gpio_pkg;
  // ==========================================================
  // Geometry
  localparam int PORT_WIDTH = 8;
  localparam int PORT_COUNT = 5;
  // Port indices
  localparam int SECOND_PORT = 0;
  localparam int THIRD_PORT = 1;
  localparam int FOURTH_PORT = 2;
  localparam int FIFTH_PORT = 3;
  localparam int SHARED_PORT = 4;
  // ==========================================================
  // Bonded pin masks per port
  localparam logic [7:0] SECOND_BONDED = 8'hff;
  localparam logic [7:0] THIRD_BONDED = 8'hc0;
  localparam logic [7:0] FOURTH_BONDED = 8'hff;
  localparam logic [7:0] FIFTH_BONDED = 8'h44;
  localparam logic [7:0] SHARED_BONDED = 8'hf3;
  // Test-interface bits of the shared port
  localparam int SHARED_BIT_SEVEN = 7;
  localparam int SHARED_BIT_FIVE = 5;
  localparam int SHARED_BIT_FOUR = 4;
  localparam logic [7:0] TEST_PULLUP_MASK = 8'hb0;
  // ==========================================================
  // Register map: one 16-byte block per port
  localparam logic [31:0] PORT_STRIDE = 32'h0000_0010;
  localparam logic [3:0] DIR_OFFSET = 4'h0;
  localparam logic [3:0] OUT_OFFSET = 4'h4;
  localparam logic [3:0] PULLUP_OFFSET = 4'h8;
  localparam logic [3:0] PIN_OFFSET = 4'hc;
  localparam logic [31:0] MAP_LIMIT = 32'h0000_0050;
  // Reset values
  localparam logic [7:0] DIR_RESET = 8'h00;
  localparam logic [7:0] OUT_RESET = 8'h00;
  localparam logic [7:0] PULLUP_RESET = 8'h00;
  // AHB encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ = 2'h3;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic HRESP_OKAY = 1'h0;
endpackage : gpio_pkg

// ---- hw/gpio_port_slice.sv ----
`timescale 1ns/1ps
// ==========================================================
// One 8-bit port: pin drive, pull-up and input synchroniser
module gpio_port_slice
  import gpio_pkg::*;
#(
  parameter logic [7:0] BONDED = 8'hff
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register side
  port_ctrl_if.slice ctrl,
  // Peripheral override
  input wire logic [7:0] alt_en,
  input wire logic [7:0] alt_out,
  input wire logic [7:0] alt_oe,
  // Analog use and forced pull-ups
  input wire logic [7:0] analog_used,
  input wire logic [7:0] force_pullup,
  // Pin side
  input wire logic [7:0] pin_in,
  output logic [7:0] pin_out,
  output logic [7:0] pin_oe,
  output logic [7:0] pin_pullup
);
  // ==========================================================
  // Signals
  logic [7:0] sync1_reg, sync1_next; // First stage, read only by second
  logic [7:0] sync2_reg, sync2_next; // Stable input sample
  logic [7:0] eff_oe; // Direction after override
  logic [7:0] eff_out; // Value after override
  logic [7:0] digital; // Bonded and not claimed by converter

  // ==========================================================
  // Drive selection
  always_comb begin
    eff_oe = (alt_en & alt_oe) | (~alt_en & ctrl.dir);
    eff_out = (alt_en & alt_out) | (~alt_en & ctrl.out);
    digital = BONDED & ~analog_used;
    // Reset releases drive without any clock edge
    pin_oe = eff_oe & digital & {8{~rst}};
    pin_out = eff_out & pin_oe;
    // Pull-up only on inputs that select it; test bits forced
    pin_pullup = (~eff_oe & ctrl.pullup_sel & digital & {8{~rst}})
      | force_pullup;
  end

  // Synchroniser next values
  always_comb begin
    sync1_next = pin_in & BONDED;
    sync2_next = sync1_reg;
  end

  // Synchroniser registers
  always_ff @(posedge clk) begin
    if (rst) begin
      sync1_reg <= 8'h00;
      sync2_reg <= 8'h00;
    end else begin
      sync1_reg <= sync1_next;
      sync2_reg <= sync2_next;
    end
  end

  // Converter channels read as zero on the digital side
  assign ctrl.sync_in = sync2_reg & ~analog_used;
endmodule : gpio_port_slice

// ---- hw/multi_port_gpio.sv ----
`timescale 1ns/1ps
// Contract
// - Every port bit independently input or output
// - Per-bit software switchable pull-up on pins
// - Reset tristates all pins without a clock
// - Third port bonds only bits 6, 7
// - Fifth port bonds only bits 2, 6
// - Shared port lacks pins 2 and 3
// - Shared pins digital only while their own converter channel is unused
// - Test enable forces pull-ups on 7,5,4
// - Peripheral function overrides plain pin control
module multi_port_gpio
  import gpio_pkg::*;
(
  // Clock and reset
  input wire logic CLK,
  input wire logic RST,
  // AHB-Lite slave
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  // Second port pins
  input wire logic [7:0] SECOND_PORT_PINS_IN,
  output logic [7:0] SECOND_PORT_PINS_OUT,
  output logic [7:0] SECOND_PORT_PINS_OE,
  output logic [7:0] SECOND_PORT_PINS_PULLUP,
  // Third port pins
  input wire logic [7:0] THIRD_PORT_PINS_IN,
  output logic [7:0] THIRD_PORT_PINS_OUT,
  output logic [7:0] THIRD_PORT_PINS_OE,
  output logic [7:0] THIRD_PORT_PINS_PULLUP,
  // Fourth port pins
  input wire logic [7:0] FOURTH_PORT_PINS_IN,
  output logic [7:0] FOURTH_PORT_PINS_OUT,
  output logic [7:0] FOURTH_PORT_PINS_OE,
  output logic [7:0] FOURTH_PORT_PINS_PULLUP,
  // Fifth port pins
  input wire logic [7:0] FIFTH_PORT_PINS_IN,
  output logic [7:0] FIFTH_PORT_PINS_OUT,
  output logic [7:0] FIFTH_PORT_PINS_OE,
  output logic [7:0] FIFTH_PORT_PINS_PULLUP,
  // Converter-shared port pins
  input wire logic [7:0] SHARED_PORT_PINS_IN,
  output logic [7:0] SHARED_PORT_PINS_OUT,
  output logic [7:0] SHARED_PORT_PINS_OE,
  output logic [7:0] SHARED_PORT_PINS_PULLUP,
  // Converter and test interface status
  input wire logic [7:0] ADC_CHANNEL_USED,
  input wire logic TEST_PORT_ENABLE,
  // Peripheral override, 8 bits per port, second port lowest
  input wire logic [39:0] ALT_ENABLE,
  input wire logic [39:0] ALT_OUT,
  input wire logic [39:0] ALT_OE,
  // Synchronised pin levels for peripherals
  output logic [39:0] PORT_SYNC
);
  // ==========================================================
  // Address decode helpers
  // Port index of a byte address
  function automatic logic [2:0] port_of(input logic [31:0] addr);
    logic [31:0] idx;
    idx = addr / PORT_STRIDE;
    port_of = idx[2:0];
  endfunction : port_of

  // Register field within the port block
  function automatic logic [3:0] field_of(input logic [31:0] addr);
    field_of = addr[3:0];
  endfunction : field_of

  // Address inside the mapped port blocks
  function automatic logic in_map(input logic [31:0] addr);
    in_map = addr < MAP_LIMIT;
  endfunction : in_map

  // Register byte widened to a bus word
  function automatic logic [31:0] widen(input logic [7:0] val);
    widen = {24'h00_0000, val};
  endfunction : widen

  // ==========================================================
  // Registers
  // Port registers
  logic [7:0] dir_reg [PORT_COUNT]; // Direction per bit
  logic [7:0] dir_next [PORT_COUNT];
  logic [7:0] out_reg [PORT_COUNT]; // Output value per bit
  logic [7:0] out_next [PORT_COUNT];
  logic [7:0] pullup_reg [PORT_COUNT]; // Pull-up select per bit
  logic [7:0] pullup_next [PORT_COUNT];
  // Bus state
  logic wr_pend_reg, wr_pend_next; // Write data phase pending
  logic [31:0] wr_addr_reg, wr_addr_next; // Write target
  logic [31:0] rdata_reg, rdata_next; // Read data for data phase
  // Port-side wiring
  logic [7:0] sync_in [PORT_COUNT]; // Synchronised inputs
  logic addr_phase; // Valid transfer sampled
  logic [7:0] test_force; // Forced pull-ups on shared port

  // ==========================================================
  // Port slice instances
  port_ctrl_if ctrl_bus [PORT_COUNT] ();

  // Second port
  gpio_port_slice #(.BONDED(SECOND_BONDED)) u_second (
    .clk(CLK),
    .rst(RST),
    .ctrl(ctrl_bus[SECOND_PORT]),
    .alt_en(ALT_ENABLE[7:0]),
    .alt_out(ALT_OUT[7:0]),
    .alt_oe(ALT_OE[7:0]),
    .analog_used(8'h00),
    .force_pullup(8'h00),
    .pin_in(SECOND_PORT_PINS_IN),
    .pin_out(SECOND_PORT_PINS_OUT),
    .pin_oe(SECOND_PORT_PINS_OE),
    .pin_pullup(SECOND_PORT_PINS_PULLUP)
  );

  // Third port, two bonded bits
  gpio_port_slice #(.BONDED(THIRD_BONDED)) u_third (
    .clk(CLK),
    .rst(RST),
    .ctrl(ctrl_bus[THIRD_PORT]),
    .alt_en(ALT_ENABLE[15:8]),
    .alt_out(ALT_OUT[15:8]),
    .alt_oe(ALT_OE[15:8]),
    .analog_used(8'h00),
    .force_pullup(8'h00),
    .pin_in(THIRD_PORT_PINS_IN),
    .pin_out(THIRD_PORT_PINS_OUT),
    .pin_oe(THIRD_PORT_PINS_OE),
    .pin_pullup(THIRD_PORT_PINS_PULLUP)
  );

  // Fourth port
  gpio_port_slice #(.BONDED(FOURTH_BONDED)) u_fourth (
    .clk(CLK),
    .rst(RST),
    .ctrl(ctrl_bus[FOURTH_PORT]),
    .alt_en(ALT_ENABLE[23:16]),
    .alt_out(ALT_OUT[23:16]),
    .alt_oe(ALT_OE[23:16]),
    .analog_used(8'h00),
    .force_pullup(8'h00),
    .pin_in(FOURTH_PORT_PINS_IN),
    .pin_out(FOURTH_PORT_PINS_OUT),
    .pin_oe(FOURTH_PORT_PINS_OE),
    .pin_pullup(FOURTH_PORT_PINS_PULLUP)
  );

  // Fifth port, two bonded bits
  gpio_port_slice #(.BONDED(FIFTH_BONDED)) u_fifth (
    .clk(CLK),
    .rst(RST),
    .ctrl(ctrl_bus[FIFTH_PORT]),
    .alt_en(ALT_ENABLE[31:24]),
    .alt_out(ALT_OUT[31:24]),
    .alt_oe(ALT_OE[31:24]),
    .analog_used(8'h00),
    .force_pullup(8'h00),
    .pin_in(FIFTH_PORT_PINS_IN),
    .pin_out(FIFTH_PORT_PINS_OUT),
    .pin_oe(FIFTH_PORT_PINS_OE),
    .pin_pullup(FIFTH_PORT_PINS_PULLUP)
  );

  // Converter-shared port
  gpio_port_slice #(.BONDED(SHARED_BONDED)) u_shared (
    .clk(CLK),
    .rst(RST),
    .ctrl(ctrl_bus[SHARED_PORT]),
    .alt_en(ALT_ENABLE[39:32]),
    .alt_out(ALT_OUT[39:32]),
    .alt_oe(ALT_OE[39:32]),
    // Converter claims and test force reach only this port
    .analog_used(ADC_CHANNEL_USED & SHARED_BONDED),
    .force_pullup(test_force),
    .pin_in(SHARED_PORT_PINS_IN),
    .pin_out(SHARED_PORT_PINS_OUT),
    .pin_oe(SHARED_PORT_PINS_OE),
    .pin_pullup(SHARED_PORT_PINS_PULLUP)
  );

  // ==========================================================
  // Test pull-ups stay on through reset, no clock involved
  assign test_force = TEST_PORT_ENABLE ? TEST_PULLUP_MASK : 8'h00;

  // ==========================================================
  // Hook register arrays onto the slices
  for (genvar p = 0; p < PORT_COUNT; p++) begin : g_hook
    assign ctrl_bus[p].dir = dir_reg[p];
    assign ctrl_bus[p].out = out_reg[p];
    assign ctrl_bus[p].pullup_sel = pullup_reg[p];
    assign sync_in[p] = ctrl_bus[p].sync_in;
    assign PORT_SYNC[p*8 +: 8] = sync_in[p];
  end

  // ==========================================================
  // Bus slave: zero wait states, always OKAY
  assign HREADYOUT = 1'b1;
  assign HRESP = HRESP_OKAY;
  // Read data from a flop, standing through the data phase
  assign HRDATA = rdata_reg;
  // Transfer taken when selected, ready and NONSEQ or SEQ
  assign addr_phase = HSEL && HREADY
    && (HTRANS == HTRANS_NONSEQ || HTRANS == HTRANS_SEQ);

  // ==========================================================
  // Next values of bus state and port registers
  always_comb begin
    logic [2:0] wp;
    logic [3:0] wf;
    logic [2:0] rp;
    logic [3:0] rf;
    // Decode write target and read source
    wp = port_of(wr_addr_reg);
    wf = field_of(wr_addr_reg);
    rp = port_of(HADDR);
    rf = field_of(HADDR);
    // Hold registers unless a write lands
    dir_next = dir_reg;
    out_next = out_reg;
    pullup_next = pullup_reg;
    // Bus state follows the address phase
    wr_pend_next = addr_phase && HWRITE;
    wr_addr_next = addr_phase ? HADDR : wr_addr_reg;
    rdata_next = 32'h0000_0000;
    // Write data phase lands in the addressed register
    if (wr_pend_reg && in_map(wr_addr_reg)) begin
      unique case (wf)
        DIR_OFFSET: begin
          // Direction, 1 drives the pin
          dir_next[wp] = HWDATA[7:0];
        end
        OUT_OFFSET: begin
          // Value driven on outputs
          out_next[wp] = HWDATA[7:0];
        end
        PULLUP_OFFSET: begin
          // Pull-up select for inputs
          pullup_next[wp] = HWDATA[7:0];
        end
        default: begin
          // Pin readback and holes ignore writes
        end
      endcase
    end
    // Read data sampled in the address phase
    if (addr_phase && !HWRITE && in_map(HADDR)) begin
      unique case (rf)
        DIR_OFFSET: begin
          // Next value, so a write just before reads back
          rdata_next = widen(dir_next[rp]);
        end
        OUT_OFFSET: begin
          // Output value register
          rdata_next = widen(out_next[rp]);
        end
        PULLUP_OFFSET: begin
          // Pull-up select register
          rdata_next = widen(pullup_next[rp]);
        end
        PIN_OFFSET: begin
          // Synchronised pin levels
          rdata_next = widen(sync_in[rp]);
        end
        default: begin
          rdata_next = 32'h0000_0000;
        end
      endcase
    end
  end

  // ==========================================================
  // Register update
  always_ff @(posedge CLK) begin
    if (RST) begin
      // Port registers to their defaults
      for (int p = 0; p < PORT_COUNT; p++) begin
        dir_reg[p] <= DIR_RESET;
        out_reg[p] <= OUT_RESET;
        pullup_reg[p] <= PULLUP_RESET;
      end
      // Bus state idle
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 32'h0000_0000;
      rdata_reg <= 32'h0000_0000;
    end else begin
      // Capture next values
      dir_reg <= dir_next;
      out_reg <= out_next;
      pullup_reg <= pullup_next;
      wr_pend_reg <= wr_pend_next;
      wr_addr_reg <= wr_addr_next;
      rdata_reg <= rdata_next;
    end
  end
endmodule : multi_port_gpio

// ---- hw/port_ctrl_if.sv ----
`timescale 1ns/1ps
// ==========================================================
// Control and readback of one port between the bus side and a port slice
interface port_ctrl_if;
  logic [7:0] dir;
  logic [7:0] out;
  logic [7:0] pullup_sel;
  logic [7:0] sync_in;
  modport ctrl (output dir, output out, output pullup_sel, input sync_in);
  modport slice (input dir, input out, input pullup_sel, output sync_in);
endinterface : port_ctrl_if

// ---- tb/board_model.sv ----
`timescale 1ns/1ps
// ==========================================
// Board side of all 40 pins
module board_model (
  // Clock
  input wire logic clk,
  // Device pin side
  input wire logic [39:0] oe,
  input wire logic [39:0] out,
  input wire logic [39:0] pull_on,
  // Board drive from the bench
  input wire logic [39:0] drive_en,
  input wire logic [39:0] drive_val,
  // Resolved pin level
  output logic [39:0] level
);
  logic [39:0] last_reg = '0; // Level of last cycle
  // Device wins, then board, then pull-up; a floating pin wanders
  always_comb begin
    level = (oe & out) | (~oe & drive_en & drive_val) | (~oe & ~drive_en & pull_on);
    level = level | (~oe & ~drive_en & ~pull_on & ~last_reg);
  end
  always_ff @(posedge clk) begin
    last_reg <= level;
  end
endmodule : board_model

// ---- tb/gpio_checker.sv ----
`timescale 1ns/1ps
// ==========================================
// Pin and bus checks at the top ports
module gpio_checker
  import gpio_pkg::*;
(
  // Clock, reset, bus answer
  input wire logic CLK,
  input wire logic RST,
  input wire logic [31:0] HRDATA,
  input wire logic HREADYOUT,
  input wire logic HRESP,
  // Pins
  input wire logic [7:0] SECOND_PORT_PINS_IN,
  input wire logic [7:0] SECOND_PORT_PINS_OUT,
  input wire logic [7:0] SECOND_PORT_PINS_OE,
  input wire logic [7:0] SECOND_PORT_PINS_PULLUP,
  input wire logic [7:0] THIRD_PORT_PINS_OE,
  input wire logic [7:0] FIFTH_PORT_PINS_OE,
  input wire logic [7:0] SHARED_PORT_PINS_OE,
  input wire logic [7:0] SHARED_PORT_PINS_PULLUP,
  // Side controls
  input wire logic [7:0] ADC_CHANNEL_USED,
  input wire logic TEST_PORT_ENABLE,
  input wire logic [39:0] ALT_ENABLE,
  input wire logic [39:0] ALT_OUT,
  input wire logic [39:0] ALT_OE,
  input wire logic [39:0] PORT_SYNC
);
  a_reset_tristate: assert property (@(posedge CLK)
    RST |-> (SECOND_PORT_PINS_OE | SHARED_PORT_PINS_OE) == 8'h00)
    else $error("pin driven in reset");
  a_test_pullup: assert property (@(posedge CLK)
    TEST_PORT_ENABLE |-> (SHARED_PORT_PINS_PULLUP & TEST_PULLUP_MASK) == TEST_PULLUP_MASK)
    else $error("test pull-up missing");
  a_third_bond: assert property (@(posedge CLK) disable iff (RST)
    (THIRD_PORT_PINS_OE & ~THIRD_BONDED) == 8'h00)
    else $error("third port unbonded drive");
  a_fifth_bond: assert property (@(posedge CLK) disable iff (RST)
    (FIFTH_PORT_PINS_OE & ~FIFTH_BONDED) == 8'h00)
    else $error("fifth port unbonded drive");
  a_shared_bond: assert property (@(posedge CLK) disable iff (RST)
    (SHARED_PORT_PINS_OE & ~SHARED_BONDED) == 8'h00)
    else $error("shared port unbonded drive");
  a_analog_gate: assert property (@(posedge CLK) disable iff (RST)
    |ADC_CHANNEL_USED |-> (SHARED_PORT_PINS_OE & ADC_CHANNEL_USED) == 8'h00)
    else $error("analog bit driven");
  a_alt_drive: assert property (@(posedge CLK) disable iff (RST)
    |ALT_ENABLE[7:0] |-> ((SECOND_PORT_PINS_OE ^ ALT_OE[7:0]) & ALT_ENABLE[7:0]) == 8'h00
    && ((SECOND_PORT_PINS_OUT ^ ALT_OUT[7:0]) & ALT_ENABLE[7:0] & ALT_OE[7:0]) == 8'h00)
    else $error("peripheral override lost");
  a_pullup_input: assert property (@(posedge CLK) disable iff (RST)
    (SECOND_PORT_PINS_PULLUP & SECOND_PORT_PINS_OE) == 8'h00)
    else $error("pull-up on output");
  a_sync_delay: assert property (@(posedge CLK) disable iff (RST)
    !$past(RST) && !$past(RST, 2) |-> PORT_SYNC[7:0] == $past(SECOND_PORT_PINS_IN, 2))
    else $error("sync delay wrong");
  a_bus_answer: assert property (@(posedge CLK) disable iff (RST)
    HRDATA[31:8] == 24'h0 && HREADYOUT && HRESP == HRESP_OKAY)
    else $error("bus answer wrong");
  // Main scenarios
  c_alt: cover property (@(posedge CLK) |ALT_ENABLE);
  c_adc: cover property (@(posedge CLK) |ADC_CHANNEL_USED);
  c_test: cover property (@(posedge CLK) TEST_PORT_ENABLE && RST);
endmodule : gpio_checker

bind multi_port_gpio gpio_checker chk (.*);

// ---- tb/multi_port_gpio_pin_logic_tb.sv ----
`timescale 1ns/1ps
// ==========================================
// Bench for the five-port pin logic
module multi_port_gpio_pin_logic_tb;
  import gpio_pkg::*;
  logic CLK = 0;
  logic RST = 1;
  logic [31:0] haddr = 0, hwdata = 0, rd;
  logic [1:0] htrans = 0;
  logic hwrite = 0, test_en = 0;
  logic [7:0] adc = 0;
  logic [39:0] alt_en = 0, alt_out = 0, alt_oe = 0, drv_en = 0, drv_val = 0;
  wire logic [39:0] oe, out, pu, lvl, sync;
  wire logic [31:0] hrdata;
  wire logic ready, hresp;
  int errors = 0, comparisons = 0;
  logic [7:0] bond [5] = '{SECOND_BONDED, THIRD_BONDED, FOURTH_BONDED, FIFTH_BONDED,
    SHARED_BONDED};
  always #5 CLK = ~CLK;
  multi_port_gpio DUT (.CLK(CLK), .RST(RST), .HSEL(1'b1), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(HSIZE_WORD), .HWDATA(hwdata), .HREADY(ready), .HRDATA(hrdata),
    .HREADYOUT(ready), .HRESP(hresp),
    .SECOND_PORT_PINS_IN(lvl[7:0]), .SECOND_PORT_PINS_OUT(out[7:0]),
    .SECOND_PORT_PINS_OE(oe[7:0]), .SECOND_PORT_PINS_PULLUP(pu[7:0]),
    .THIRD_PORT_PINS_IN(lvl[15:8]), .THIRD_PORT_PINS_OUT(out[15:8]),
    .THIRD_PORT_PINS_OE(oe[15:8]), .THIRD_PORT_PINS_PULLUP(pu[15:8]),
    .FOURTH_PORT_PINS_IN(lvl[23:16]), .FOURTH_PORT_PINS_OUT(out[23:16]),
    .FOURTH_PORT_PINS_OE(oe[23:16]), .FOURTH_PORT_PINS_PULLUP(pu[23:16]),
    .FIFTH_PORT_PINS_IN(lvl[31:24]), .FIFTH_PORT_PINS_OUT(out[31:24]),
    .FIFTH_PORT_PINS_OE(oe[31:24]), .FIFTH_PORT_PINS_PULLUP(pu[31:24]),
    .SHARED_PORT_PINS_IN(lvl[39:32]), .SHARED_PORT_PINS_OUT(out[39:32]),
    .SHARED_PORT_PINS_OE(oe[39:32]), .SHARED_PORT_PINS_PULLUP(pu[39:32]),
    .ADC_CHANNEL_USED(adc), .TEST_PORT_ENABLE(test_en), .ALT_ENABLE(alt_en),
    .ALT_OUT(alt_out), .ALT_OE(alt_oe), .PORT_SYNC(sync));
  board_model BRD (.clk(CLK), .oe(oe), .out(out), .pull_on(pu), .drive_en(drv_en),
    .drive_val(drv_val), .level(lvl));
  // One single AHB transfer, read data kept in rd
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge CLK);
    haddr <= a;
    hwrite <= w;
    htrans <= HTRANS_NONSEQ;
    do @(posedge CLK); while (ready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge CLK); while (ready !== 1'b1);
    rd = hrdata;
  endtask : bus
  function automatic logic [31:0] ra(input int p, input logic [3:0] o);
    return 32'(p) * PORT_STRIDE + 32'(o);
  endfunction : ra
  task automatic check(input string n, input logic [39:0] e, input logic [39:0] s);
    comparisons++;
    if (s !== e) begin
      errors++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask : check
  task automatic rdchk(input string n, input logic [31:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    check(n, {8'h0, e}, {8'h0, rd});
  endtask : rdchk
  task automatic conclude;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : conclude
  // Main sequence
  initial begin
    repeat (8) @(posedge CLK);
    check("reset oe", 40'h0, oe);
    check("reset pullup", 40'h0, pu);
    test_en <= 1'b1;
    @(negedge CLK);
    check("test pullup", {TEST_PULLUP_MASK, 32'h0}, pu);
    repeat (8) @(posedge CLK);
    RST <= 1'b0;
    test_en <= 1'b0;
    $display("test reset done");
    for (int p = 0; p < 5; p++) begin
      bus(1'b1, ra(p, DIR_OFFSET), 32'hff);
      @(negedge CLK);
      check("bonded oe", {32'h0, bond[p]}, {32'h0, oe[8*p +: 8]});
      bus(1'b1, ra(p, DIR_OFFSET), 32'h0);
      bus(1'b1, ra(p, PULLUP_OFFSET), 32'hff);
      @(negedge CLK);
      check("bonded pullup", {32'h0, bond[p]}, {32'h0, pu[8*p +: 8]});
      repeat (3) @(posedge CLK);
      rdchk("pulled pin", ra(p, PIN_OFFSET), {24'h0, bond[p]});
      drv_en[8*p +: 8] <= 8'hff;
      drv_val[8*p +: 8] <= 8'h5a;
      repeat (3) @(posedge CLK);
      rdchk("driven pin", ra(p, PIN_OFFSET), {24'h0, 8'h5a & bond[p]});
      rdchk("pullup reg", ra(p, PULLUP_OFFSET), 32'hff);
      drv_en[8*p +: 8] <= 8'h0;
    end
    $display("test bonding done");
    bus(1'b1, ra(0, DIR_OFFSET), 32'h0f);
    bus(1'b1, ra(0, OUT_OFFSET), 32'h05);
    drv_en[7:0] <= 8'hf0;
    drv_val[7:0] <= 8'ha0;
    @(negedge CLK);
    check("mixed oe", 40'h0f, {32'h0, oe[7:0]});
    check("mixed pullup", 40'hf0, {32'h0, pu[7:0]});
    repeat (3) @(posedge CLK);
    rdchk("mixed pin", ra(0, PIN_OFFSET), 32'ha5);
    check("sync", 40'ha5, {32'h0, sync[7:0]});
    rdchk("dir reg", ra(0, DIR_OFFSET), 32'h0f);
    $display("test direction done");
    bus(1'b1, ra(4, DIR_OFFSET), 32'hff);
    adc <= 8'h10;
    @(negedge CLK);
    check("analog oe", 40'he3, {32'h0, oe[39:32]});
    alt_en[7:0] <= 8'h0f;
    alt_oe[7:0] <= 8'hff;
    alt_out[7:0] <= 8'h3c;
    @(negedge CLK);
    check("alt oe", 40'h0f, {32'h0, oe[7:0]});
    check("alt out", 40'h0c, {32'h0, out[7:0]});
    rdchk("hole", MAP_LIMIT, 32'h0);
    $display("test override done");
    RST <= 1'b1;
    @(negedge CLK);
    check("midrun reset oe", 40'h0, oe);
    check("midrun reset pullup", 40'h0, pu);
    repeat (2) @(posedge CLK);
    RST <= 1'b0;
    rdchk("cleared dir", ra(0, DIR_OFFSET), {24'h0, DIR_RESET});
    $display("test reset again done");
    conclude();
  end
  // Watchdog
  initial begin
    repeat (20000) @(posedge CLK);
    errors++;
    conclude();
  end
endmodule : multi_port_gpio_pin_logic_tb
